// ==== hdms_consts.svh ====
`ifndef HDMS_CONSTS_SVH
`define HDMS_CONSTS_SVH
// ****************************************
// core debug register numbers
// ****************************************
`define HDMS_CSR_DCSR 12'h7B0
`define HDMS_CSR_DPC 12'h7B1
`define HDMS_CSR_DSCR 12'h7B2
`define HDMS_DRET_WORD 32'h7B200073
// ****************************************
// debug control field positions
// ****************************************
`define HDMS_VER_LSB 30
`define HDMS_NDRST_BIT 29
`define HDMS_FULLRST_BIT 28
`define HDMS_EBM_BIT 15
`define HDMS_EBH_BIT 14
`define HDMS_EBS_BIT 13
`define HDMS_EBU_BIT 12
`define HDMS_STOPCYC_BIT 10
`define HDMS_STOPTIME_BIT 9
`define HDMS_CAUSE_LSB 6
`define HDMS_DBGINT_BIT 5
`define HDMS_HALT_BIT 3
`define HDMS_STEP_BIT 2
`define HDMS_PRV_LSB 0
// ****************************************
// field values and reset values
// ****************************************
`define HDMS_VER_NONE 2'h0
`define HDMS_VER_DEBUG 2'h1
`define HDMS_STOPCYC_RST 1'b1
`define HDMS_CAUSE_NONE 3'h0
`define HDMS_CAUSE_EBREAK 3'h1
`define HDMS_CAUSE_TRIG 3'h2
`define HDMS_CAUSE_DBGINT 3'h3
`define HDMS_CAUSE_STEP 3'h4
`define HDMS_CAUSE_HALT 3'h5
`define HDMS_PRV_U 2'h0
`define HDMS_PRV_S 2'h1
`define HDMS_PRV_H 2'h2
`define HDMS_PRV_M 2'h3
`define HDMS_RAM_DONE_WORD 32'h00000000
`define HDMS_RAM_EXC_WORD 32'hFFFFFFFF
// ****************************************
// debug module addresses
// ****************************************
`define HDMS_DM_CLRINT 12'h100
`define HDMS_DM_HALTNOT 12'h10C
`define HDMS_DM_RAM_BASE 12'h400
`define HDMS_DM_RAM_WORDS 16
`endif

// ==== hdms_pkg.sv ====
package hdms_pkg;
  typedef enum logic [10:0] {
    HDMS_RUN = 11'b000_0000_0001,
    HDMS_ENTER = 11'b000_0000_0010,
    HDMS_NOTIFY = 11'b000_0000_0100,
    HDMS_WAIT_INT = 11'b000_0000_1000,
    HDMS_SAVE = 11'b000_0001_0000,
    HDMS_RAM = 11'b000_0010_0000,
    HDMS_RD_S1 = 11'b000_0100_0000,
    HDMS_MARK = 11'b000_1000_0000,
    HDMS_CLEAR = 11'b001_0000_0000,
    HDMS_RESTORE = 11'b010_0000_0000,
    HDMS_EXIT = 11'b100_0000_0000
  } hdms_state_type;
endpackage

// ==== hdms_bus_port.sv ====
`timescale 1ns/10ps
// ****************************************
// single-request master toward the debug module
// ****************************************
module hdms_bus_port (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic start_we,
  input wire logic [11:0] start_addr,
  input wire logic [31:0] start_wdata,
  output logic dm_req,
  output logic dm_we,
  output logic [11:0] dm_addr,
  output logic [31:0] dm_wdata,
  input wire logic dm_ack,
  output logic done
);
  logic req_q;
  logic we_q;
  logic [11:0] addr_q;
  logic [31:0] wdata_q;

  // request stands until the slave acks it; a start while busy is ignored
  assign done = req_q & dm_ack;
  assign dm_req = req_q;
  assign dm_we = we_q;
  assign dm_addr = addr_q;
  assign dm_wdata = wdata_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      req_q <= 1'b0;
    end else if (done) begin
      req_q <= 1'b0;
    end else if (start) begin
      req_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      we_q <= 1'b0;
      addr_q <= 12'h000;
      wdata_q <= 32'h00000000;
    end else if (start && !req_q) begin
      we_q <= start_we;
      addr_q <= start_addr;
      wdata_q <= start_wdata;
    end
  end
endmodule // hdms_bus_port

// ==== hdms_debug_unit.sv ====
`timescale 1ns/10ps
`include "hdms_consts.svh"
module hdms_debug_unit import hdms_pkg::*; #(
  parameter logic [9:0] HART_ID = 10'h000,
  parameter logic [11:0] RAM_BASE = `HDMS_DM_RAM_BASE,
  parameter int RAM_WORDS = `HDMS_DM_RAM_WORDS,
  parameter bit STOPCYC_WRITABLE = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] cur_pc,
  input wire logic [1:0] cur_priv,
  input wire logic instr_retire,
  input wire logic ebreak_exec,
  input wire logic trigger_hit,
  input wire logic dbg_exc,
  input wire logic ram_done,
  input wire logic debug_int,
  input wire logic [31:0] s0_value,
  input wire logic [31:0] s1_value,
  input wire logic csr_valid,
  input wire logic csr_write,
  input wire logic [11:0] csr_addr,
  input wire logic [31:0] csr_wdata,
  output logic [31:0] csr_rdata,
  output logic csr_resp,
  output logic csr_fault,
  output logic dm_req,
  output logic dm_we,
  output logic [11:0] dm_addr,
  output logic [31:0] dm_wdata,
  input wire logic dm_ack,
  input wire logic [31:0] dm_rdata,
  output logic debug_mode,
  output logic core_stall,
  output logic irq_mask,
  output logic count_inhibit,
  output logic resv_drop,
  output logic illegal_instr,
  output logic redirect_valid,
  output logic [31:0] redirect_pc,
  output logic [1:0] redirect_priv,
  output logic gpr_restore,
  output logic [31:0] s0_restore,
  output logic [31:0] s1_restore,
  output logic hart_reset_req
);
  // ****************************************
  // state and registers
  // ****************************************
  hdms_state_type state_q, state_d;
  logic halt_q, step_q, stopcyc_q, exc_q, issued_q;
  logic [3:0] ebreak_en_q;
  logic [1:0] prv_q;
  logic [2:0] cause_q, cause_d;
  logic [31:0] dpc_q, dscr_q, s1_hold_q;
  logic nd_pulse_q, full_pulse_q;
  logic [31:0] csr_rdata_q;
  logic csr_resp_q, csr_fault_q, illegal_q, resv_q;
  logic redir_q, restore_q;
  logic [31:0] redir_pc_q, s0_rest_q, s1_rest_q;
  logic [1:0] redir_priv_q;

  logic rst_keep, rst_all;
  logic in_run, in_ram, dret_hit, ebreak_go, step_go, enter_go;
  logic is_bus_state, bus_start, bus_we, bus_done;
  logic [11:0] bus_addr, ram_last;
  logic [31:0] bus_wdata, dcsr_value;
  logic csr_ok, csr_hit_dcsr, csr_hit_dpc, csr_hit_dscr, csr_wr_ok;

  // ****************************************
  // resets requested by the debugger
  // ****************************************
  // all debug logic
  assign rst_all = reset | full_pulse_q;
  assign rst_keep = rst_all | nd_pulse_q;
  assign hart_reset_req = nd_pulse_q | full_pulse_q;

  // ****************************************
  // decode
  // ****************************************
  assign in_run = state_q[0];
  assign in_ram = (state_q == HDMS_RAM);
  assign debug_mode = ~in_run;
  assign core_stall = debug_mode & ~in_ram;
  assign irq_mask = debug_mode | step_q;
  assign count_inhibit = debug_mode & stopcyc_q;
  assign dret_hit = instr_valid & (instr_word == `HDMS_DRET_WORD);
  assign ebreak_go = ebreak_exec & ebreak_en_q[cur_priv];
  assign step_go = step_q & instr_retire;
  assign enter_go = in_run & (step_go | debug_int | ebreak_go | trigger_hit | halt_q);

  assign cause_d = step_go ? `HDMS_CAUSE_STEP :
                   debug_int ? `HDMS_CAUSE_DBGINT :
                   ebreak_go ? `HDMS_CAUSE_EBREAK :
                   trigger_hit ? `HDMS_CAUSE_TRIG : `HDMS_CAUSE_HALT;

  // ****************************************
  // routine sequencer
  // ****************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      HDMS_RUN: begin
        if (enter_go) begin
          state_d = HDMS_ENTER;
        end
      end
      HDMS_ENTER: begin
        state_d = (cause_q == `HDMS_CAUSE_DBGINT) ? HDMS_SAVE : HDMS_NOTIFY;
      end
      HDMS_NOTIFY: begin
        if (bus_done) begin
          state_d = HDMS_WAIT_INT;
        end
      end
      HDMS_WAIT_INT: begin
        if (debug_int) begin
          state_d = HDMS_SAVE;
        end
      end
      HDMS_SAVE: begin
        if (bus_done) begin
          state_d = HDMS_RAM;
        end
      end
      HDMS_RAM: begin
        if (dret_hit) begin
          state_d = HDMS_EXIT;
        end else if (ram_done || dbg_exc) begin
          state_d = HDMS_RD_S1;
        end
      end
      HDMS_RD_S1: begin
        if (bus_done) begin
          state_d = HDMS_MARK;
        end
      end
      HDMS_MARK: begin
        if (bus_done) begin
          state_d = HDMS_CLEAR;
        end
      end
      HDMS_CLEAR: begin
        if (bus_done) begin
          state_d = HDMS_RESTORE;
        end
      end
      HDMS_RESTORE: begin
        state_d = halt_q ? HDMS_WAIT_INT : HDMS_EXIT;
      end
      HDMS_EXIT: begin
        state_d = HDMS_RUN;
      end
      default: begin
        state_d = HDMS_RUN;
      end
    endcase
  end

  // ****************************************
  // bus requests of the routines
  // ****************************************
  assign ram_last = RAM_BASE + 12'(4 * (RAM_WORDS - 1));
  assign is_bus_state = (state_q == HDMS_NOTIFY) | (state_q == HDMS_SAVE) |
                        (state_q == HDMS_RD_S1) | (state_q == HDMS_MARK) |
                        (state_q == HDMS_CLEAR);
  assign bus_start = is_bus_state & ~issued_q;
  assign bus_we = (state_q != HDMS_RD_S1);
  assign bus_addr = (state_q == HDMS_NOTIFY) ? `HDMS_DM_HALTNOT :
                    (state_q == HDMS_CLEAR) ? `HDMS_DM_CLRINT : ram_last;
  assign bus_wdata = (state_q == HDMS_SAVE) ? s1_value :
                     (state_q == HDMS_MARK) ? (exc_q ? `HDMS_RAM_EXC_WORD :
                                               `HDMS_RAM_DONE_WORD) :
                     {22'h000000, HART_ID};

  hdms_bus_port u_bus (
    .clk(clk),
    .reset(rst_keep),
    .start(bus_start),
    .start_we(bus_we),
    .start_addr(bus_addr),
    .start_wdata(bus_wdata),
    .dm_req(dm_req),
    .dm_we(dm_we),
    .dm_addr(dm_addr),
    .dm_wdata(dm_wdata),
    .dm_ack(dm_ack),
    .done(bus_done)
  );

  always_ff @(posedge clk) begin
    if (rst_keep) begin
      state_q <= HDMS_RUN;
      issued_q <= 1'b0;
    end else begin
      state_q <= state_d;
      issued_q <= bus_start | (issued_q & ~bus_done);
    end
  end

  // ****************************************
  // core debug register access
  // ****************************************
  // version reads one
  assign dcsr_value = {`HDMS_VER_DEBUG, 2'b00, 12'h000, ebreak_en_q, 1'b0, stopcyc_q,
                       1'b0, cause_q, debug_int, 1'b0, halt_q, step_q, prv_q};
  assign csr_hit_dcsr = (csr_addr == `HDMS_CSR_DCSR);
  assign csr_hit_dpc = (csr_addr == `HDMS_CSR_DPC);
  assign csr_hit_dscr = (csr_addr == `HDMS_CSR_DSCR);
  assign csr_ok = csr_valid & debug_mode & (csr_hit_dcsr | csr_hit_dpc | csr_hit_dscr);
  assign csr_wr_ok = csr_ok & csr_write;

  always_ff @(posedge clk) begin
    if (rst_all) begin
      csr_rdata_q <= 32'h00000000;
      csr_resp_q <= 1'b0;
      csr_fault_q <= 1'b0;
    end else begin
      csr_resp_q <= csr_valid;
      csr_fault_q <= csr_valid & ~csr_ok;
      csr_rdata_q <= ~csr_ok ? 32'h00000000 : csr_hit_dcsr ? dcsr_value :
                     csr_hit_dpc ? dpc_q : dscr_q;
    end
  end
  assign csr_rdata = csr_rdata_q;
  assign csr_resp = csr_resp_q;
  assign csr_fault = csr_fault_q;

  always_ff @(posedge clk) begin
    if (rst_keep) begin
      nd_pulse_q <= 1'b0;
      full_pulse_q <= 1'b0;
    end else begin
      nd_pulse_q <= csr_wr_ok & csr_hit_dcsr & csr_wdata[`HDMS_NDRST_BIT];
      full_pulse_q <= csr_wr_ok & csr_hit_dcsr & csr_wdata[`HDMS_FULLRST_BIT];
    end
  end

  // halt survives the keep-halt reset; the routine sets it after notifying
  always_ff @(posedge clk) begin
    if (rst_all) begin
      halt_q <= 1'b0;
    end else if ((state_q == HDMS_NOTIFY) && bus_done) begin
      halt_q <= 1'b1;
    end else if (csr_wr_ok && csr_hit_dcsr) begin
      halt_q <= csr_wdata[`HDMS_HALT_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst_keep) begin
      step_q <= 1'b0;
      ebreak_en_q <= 4'h0;
      stopcyc_q <= `HDMS_STOPCYC_RST;
      prv_q <= `HDMS_PRV_U;
    end else if (state_q == HDMS_ENTER) begin
      prv_q <= cur_priv;
    end else if (csr_wr_ok && csr_hit_dcsr) begin
      step_q <= csr_wdata[`HDMS_STEP_BIT];
      ebreak_en_q <= {csr_wdata[`HDMS_EBM_BIT], csr_wdata[`HDMS_EBH_BIT],
                      csr_wdata[`HDMS_EBS_BIT], csr_wdata[`HDMS_EBU_BIT]};
      stopcyc_q <= STOPCYC_WRITABLE ? csr_wdata[`HDMS_STOPCYC_BIT] : `HDMS_STOPCYC_RST;
      prv_q <= csr_wdata[`HDMS_PRV_LSB +: 2];
    end
  end

  always_ff @(posedge clk) begin
    if (rst_keep) begin
      cause_q <= `HDMS_CAUSE_NONE;
      dpc_q <= 32'h00000000;
      exc_q <= 1'b0;
    end else if (enter_go) begin
      cause_q <= cause_d;
      dpc_q <= cur_pc;
    end else if (state_q == HDMS_EXIT) begin
      cause_q <= `HDMS_CAUSE_NONE;
    end else if (in_ram && (ram_done || dbg_exc)) begin
      exc_q <= dbg_exc;
    end else if (csr_wr_ok && csr_hit_dpc) begin
      dpc_q <= csr_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_keep) begin
      dscr_q <= 32'h00000000;
      s1_hold_q <= 32'h00000000;
    end else if ((state_q == HDMS_SAVE) && bus_start) begin
      dscr_q <= s0_value;
    end else if ((state_q == HDMS_RD_S1) && bus_done) begin
      s1_hold_q <= dm_rdata;
    end else if (csr_wr_ok && csr_hit_dscr) begin
      dscr_q <= csr_wdata;
    end
  end

  // ****************************************
  // effects on the core
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst_keep) begin
      illegal_q <= 1'b0;
      resv_q <= 1'b0;
      redir_q <= 1'b0;
      redir_pc_q <= 32'h00000000;
      redir_priv_q <= `HDMS_PRV_M;
      restore_q <= 1'b0;
      s0_rest_q <= 32'h00000000;
      s1_rest_q <= 32'h00000000;
    end else begin
      illegal_q <= dret_hit & in_run;
      resv_q <= (state_q == HDMS_ENTER);
      redir_q <= (state_q == HDMS_SAVE && bus_done) || (state_q == HDMS_EXIT);
      redir_pc_q <= (state_q == HDMS_EXIT) ? dpc_q : {20'h00000, RAM_BASE};
      redir_priv_q <= (state_q == HDMS_EXIT) ? prv_q : `HDMS_PRV_M;
      restore_q <= (state_q == HDMS_RESTORE);
      s0_rest_q <= dscr_q;
      s1_rest_q <= s1_hold_q;
    end
  end
  assign illegal_instr = illegal_q;
  assign resv_drop = resv_q;
  assign redirect_valid = redir_q;
  assign redirect_pc = redir_pc_q;
  assign redirect_priv = redir_priv_q;
  assign gpr_restore = restore_q;
  assign s0_restore = s0_rest_q;
  assign s1_restore = s1_rest_q;
endmodule // hdms_debug_unit

// ==== hdms_debug_monitor.sv ====
`timescale 1ns/10ps
// ********************
// port checker
// ********************
module hdms_debug_monitor #(
  parameter logic [9:0] HART_ID = 10'h000,
  parameter logic [11:0] RAM_BASE = 12'h400
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic csr_valid,
  input wire logic csr_write,
  input wire logic [11:0] csr_addr,
  input wire logic [31:0] csr_wdata,
  input wire logic [31:0] csr_rdata,
  input wire logic csr_resp,
  input wire logic csr_fault,
  input wire logic dm_req,
  input wire logic dm_we,
  input wire logic [11:0] dm_addr,
  input wire logic [31:0] dm_wdata,
  input wire logic dm_ack,
  input wire logic debug_mode,
  input wire logic irq_mask,
  input wire logic count_inhibit,
  input wire logic resv_drop,
  input wire logic illegal_instr,
  input wire logic redirect_valid,
  input wire logic [31:0] redirect_pc,
  input wire logic [1:0] redirect_priv,
  input wire logic hart_reset_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_CSR_GUARD: assert property (
    csr_valid && (!debug_mode || csr_addr < 12'h7B0 || csr_addr > 12'h7B2)
    |=> csr_resp && csr_fault && csr_rdata == 32'h0) else $error("csr access not refused");
  AST_DRET_ILL: assert property (
    instr_valid && instr_word == 32'h7B200073 && !debug_mode |-> ##[1:2] illegal_instr)
    else $error("debug return outside debug mode not refused");
  AST_HALTNOT: assert property (
    dm_req && dm_addr == 12'h10C |-> dm_we && dm_wdata == {22'h0, HART_ID})
    else $error("halt notify write wrong");
  AST_CLRINT: assert property (
    dm_req && dm_addr == 12'h100 |-> dm_we && dm_wdata == {22'h0, HART_ID})
    else $error("interrupt clear write wrong");
  AST_REQ_HOLD: assert property (
    dm_req && !dm_ack |=> dm_req && $stable(dm_addr) && $stable(dm_wdata) && $stable(dm_we))
    else $error("bus request changed before ack");
  AST_RAM_PRIV: assert property (
    redirect_valid && redirect_pc == {20'h0, RAM_BASE} |-> redirect_priv == 2'h3 && debug_mode)
    else $error("jump to debug ram not in machine level");
  AST_RESV: assert property (
    $rose(debug_mode) |-> (resv_drop || $past(resv_drop)) or ##1 resv_drop)
    else $error("reservation not dropped on entry");
  AST_IRQ: assert property (
    debug_mode |-> irq_mask) else $error("interrupts open in debug mode");
  AST_COUNT: assert property (
    count_inhibit |-> debug_mode) else $error("counters held outside debug mode");
  AST_EXIT: assert property (
    redirect_valid && redirect_pc != {20'h0, RAM_BASE} |-> ##[0:2] !debug_mode)
    else $error("return did not leave debug mode");
  AST_RESET_REQ: assert property (
    csr_valid && csr_write && csr_addr == 12'h7B0 && debug_mode && (csr_wdata[29] || csr_wdata[28])
    |-> ##[1:2] hart_reset_req) else $error("hart reset not requested");
endmodule // hdms_debug_monitor

// ==== hdms_dm_model.sv ====
`timescale 1ns/10ps
// ********************
// debug module stand-in
// ********************
module hdms_dm_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] delay,
  input wire logic raise_int,
  input wire logic lower_int,
  input wire logic dm_req,
  input wire logic dm_we,
  input wire logic [11:0] dm_addr,
  input wire logic [31:0] dm_wdata,
  output logic dm_ack,
  output logic [31:0] dm_rdata,
  output logic debug_int,
  output logic [31:0] ram_last,
  output logic [9:0] halt_id,
  output int notify_cnt,
  output int clear_cnt
);
  logic [3:0] wait_q;
  // read lines carry junk outside the ack cycle, so a late sample shows up
  assign dm_rdata = dm_ack ? ram_last : ~ram_last;
  // ack after a chosen delay, so slow answers are tried too
  always @(posedge clk) begin
    dm_ack <= 1'b0;
    if (raise_int)
      debug_int <= 1'b1;
    if (lower_int)
      debug_int <= 1'b0;
    if (reset) begin
      debug_int <= 1'b0;
      wait_q <= 4'h0;
      ram_last <= 32'hA5A5A5A5;
      notify_cnt <= 0;
      clear_cnt <= 0;
    end else if (dm_req && !dm_ack) begin
      wait_q <= wait_q + 4'h1;
      if (wait_q >= delay) begin
        wait_q <= 4'h0;
        dm_ack <= 1'b1;
        if (dm_we && dm_addr == 12'h43C)
          ram_last <= dm_wdata;
        if (dm_we && dm_addr == 12'h10C) begin
          halt_id <= dm_wdata[9:0];
          notify_cnt <= notify_cnt + 1;
        end
        if (dm_we && dm_addr == 12'h100) begin
          debug_int <= 1'b0;
          clear_cnt <= clear_cnt + 1;
        end
      end
    end
  end
endmodule // hdms_dm_model

// ==== hart_debug_mode_support_tb.sv ====
`timescale 1ns/10ps
// ********************
// debug unit bench
// ********************
module hart_debug_mode_support_tb;
  logic clk, flt, reset = 1'b1;
  logic instr_valid, instr_retire, ebreak_exec, trigger_hit, dbg_exc, ram_done, raise_int;
  logic lower_int, csr_valid, csr_write, dm_req, dm_we, dm_ack, debug_int, csr_resp, csr_fault;
  logic debug_mode, irq_mask, count_inhibit, illegal_instr, redirect_valid, gpr_restore;
  logic hart_reset_req, core_stall;
  logic [31:0] instr_word, cur_pc, s0_value, s1_value, csr_wdata, csr_rdata, dm_wdata;
  logic [31:0] redirect_pc, s0_restore, s1_restore, dm_rdata, ram_last, rd;
  logic [11:0] csr_addr, dm_addr;
  logic [1:0] cur_priv, redirect_priv;
  logic [9:0] halt_id;
  logic [3:0] delay = 4'h0;
  int notify_cnt, clear_cnt, n, cycles = 0, mismatches = 0, checks_done = 0;
  hdms_debug_unit #(.HART_ID(10'h005)) i_dut (.clk(clk), .reset(reset),
    .instr_valid(instr_valid), .instr_word(instr_word), .cur_pc(cur_pc), .cur_priv(cur_priv),
    .instr_retire(instr_retire), .ebreak_exec(ebreak_exec), .trigger_hit(trigger_hit),
    .dbg_exc(dbg_exc), .ram_done(ram_done), .debug_int(debug_int), .s0_value(s0_value),
    .s1_value(s1_value), .csr_valid(csr_valid), .csr_write(csr_write), .csr_addr(csr_addr),
    .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .csr_resp(csr_resp), .csr_fault(csr_fault),
    .dm_req(dm_req), .dm_we(dm_we), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_ack(dm_ack),
    .dm_rdata(dm_rdata), .debug_mode(debug_mode), .core_stall(core_stall), .irq_mask(irq_mask),
    .count_inhibit(count_inhibit), .resv_drop(), .illegal_instr(illegal_instr),
    .redirect_valid(redirect_valid), .redirect_pc(redirect_pc), .redirect_priv(redirect_priv),
    .gpr_restore(gpr_restore), .s0_restore(s0_restore), .s1_restore(s1_restore),
    .hart_reset_req(hart_reset_req));
  hdms_dm_model u_dm (.clk(clk), .reset(reset), .delay(delay), .raise_int(raise_int),
    .lower_int(lower_int), .dm_req(dm_req), .dm_we(dm_we), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .dm_ack(dm_ack), .debug_int(debug_int), .ram_last(ram_last),
    .dm_rdata(dm_rdata), .halt_id(halt_id), .notify_cnt(notify_cnt), .clear_cnt(clear_cnt));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic close_out;
    if (mismatches == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // a hang ends in the same report
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      close_out;
    end
  end
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick;
    s = 1'b0;
  endtask
  task automatic csr_op(input logic we, input logic [11:0] a, input logic [31:0] wd);
    // one idle edge so a back-to-back call never flips the strobe in one step
    tick;
    csr_valid = 1'b1;
    csr_write = we;
    csr_addr = a;
    csr_wdata = wd;
    tick;
    csr_valid = 1'b0;
    rd = csr_rdata;
    flt = csr_fault;
    chk("csr_resp", 32'h1, 32'(csr_resp));
  endtask
  task automatic csr_rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    csr_op(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  task automatic await_redirect(input logic [31:0] pc, input logic [1:0] pv);
    for (n = 0; n < 60 && redirect_valid !== 1'b1; n++)
      tick;
    chk("redirect_valid", 32'h1, 32'(redirect_valid));
    chk("redirect_pc", pc, redirect_pc);
    chk("redirect_priv", 32'(pv), 32'(redirect_priv));
    tick;
  endtask
  initial begin
    {instr_valid, instr_retire, ebreak_exec, trigger_hit, dbg_exc, ram_done} = 6'h0;
    {raise_int, lower_int, csr_valid, csr_write} = 4'h0;
    instr_word = 32'h7B200073;
    cur_pc = 32'h1234;
    cur_priv = 2'h1;
    s0_value = 32'h5000000A;
    s1_value = 32'h6000000B;
    csr_addr = 12'h0;
    csr_wdata = 32'h0;
    repeat (3) @(posedge clk);
    #1;
    reset = 1'b0;
    tick;
    csr_rd("dcsr_out", 12'h7B0, 32'h0);
    chk("fault_out", 32'h1, 32'(flt));
    pulse(instr_valid);
    for (n = 0; n < 4 && illegal_instr !== 1'b1; n++)
      tick;
    chk("illegal", 32'h1, 32'(illegal_instr));
    cur_priv = 2'h3;
    pulse(ebreak_exec);
    repeat (8) tick;
    chk("ebreak_off", 32'h0, 32'(debug_mode));
    cur_priv = 2'h1;
    pulse(raise_int);
    await_redirect(32'h400, 2'h3);
    chk("notify_skip", 32'h0, 32'(notify_cnt));
    s0_value = 32'h0;
    csr_rd("dcsr_int", 12'h7B0, 32'h400004E1);
    csr_rd("dpc", 12'h7B1, 32'h1234);
    csr_rd("dscratch", 12'h7B2, 32'h5000000A);
    chk("s1_saved", 32'h6000000B, ram_last);
    chk("freeze_on", 32'h1, 32'(count_inhibit));
    chk("stall_ram", 32'h0, 32'(core_stall));
    csr_rd("unmapped", 12'h7B3, 32'h0);
    chk("fault_unmapped", 32'h1, 32'(flt));
    csr_op(1'b1, 12'h7B0, 32'hC00011E0);
    csr_rd("dcsr_wr", 12'h7B0, 32'h400010E0);
    pulse(ram_done);
    for (n = 0; n < 40 && gpr_restore !== 1'b1; n++)
      tick;
    chk("s0_restore", 32'h5000000A, s0_restore);
    chk("s1_restore", 32'h6000000B, s1_restore);
    await_redirect(32'h1234, 2'h0);
    chk("ram_zero", 32'h0, ram_last);
    chk("clear_cnt", 32'h1, 32'(clear_cnt));
    chk("left", 32'h0, 32'(debug_mode));
    // slow far side from here on
    delay = 4'h3;
    cur_priv = 2'h0;
    pulse(ebreak_exec);
    for (n = 0; n < 40 && notify_cnt != 1; n++)
      tick;
    chk("halt_id", 32'h5, 32'(halt_id));
    repeat (3) tick;
    chk("waiting", 32'h1, 32'(debug_mode));
    chk("stall_wait", 32'h1, 32'(core_stall));
    pulse(raise_int);
    await_redirect(32'h400, 2'h3);
    csr_rd("dcsr_brk", 12'h7B0, 32'h40001068);
    chk("freeze_off", 32'h0, 32'(count_inhibit));
    pulse(dbg_exc);
    for (n = 0; n < 60 && clear_cnt != 2; n++)
      tick;
    chk("ram_ones", 32'hFFFFFFFF, ram_last);
    repeat (3) tick;
    chk("rewait", 32'h1, 32'(debug_mode));
    pulse(raise_int);
    await_redirect(32'h400, 2'h3);
    csr_op(1'b1, 12'h7B1, 32'h3000);
    csr_op(1'b1, 12'h7B0, 32'h407);
    pulse(lower_int);
    cur_priv = 2'h3;
    pulse(instr_valid);
    await_redirect(32'h3000, 2'h3);
    chk("step_mask", 32'h1, 32'(irq_mask));
    chk("step_run", 32'h0, 32'(debug_mode));
    trigger_hit = 1'b1;
    pulse(instr_retire);
    trigger_hit = 1'b0;
    for (n = 0; n < 60 && notify_cnt != 2; n++)
      tick;
    pulse(raise_int);
    await_redirect(32'h400, 2'h3);
    csr_rd("dcsr_step", 12'h7B0, 32'h4000052F);
    pulse(lower_int);
    csr_op(1'b1, 12'h7B0, 32'h20000008);
    for (n = 0; n < 8 && hart_reset_req !== 1'b1; n++)
      tick;
    chk("nd_req", 32'h1, 32'(hart_reset_req));
    for (n = 0; n < 60 && notify_cnt != 3; n++)
      tick;
    pulse(raise_int);
    await_redirect(32'h400, 2'h3);
    csr_rd("dcsr_nd", 12'h7B0, 32'h4000056B);
    pulse(lower_int);
    csr_op(1'b1, 12'h7B0, 32'h10000008);
    for (n = 0; n < 8 && hart_reset_req !== 1'b1; n++)
      tick;
    repeat (4) tick;
    chk("full_out", 32'h0, 32'(debug_mode));
    csr_rd("dcsr_gone", 12'h7B0, 32'h0);
    close_out;
  end
endmodule // hart_debug_mode_support_tb
bind hdms_debug_unit hdms_debug_monitor #(.HART_ID(HART_ID), .RAM_BASE(RAM_BASE)) u_mon (
  .clk(clk), .reset(reset), .instr_valid(instr_valid), .instr_word(instr_word),
  .csr_valid(csr_valid), .csr_write(csr_write), .csr_addr(csr_addr), .csr_wdata(csr_wdata),
  .csr_rdata(csr_rdata), .csr_resp(csr_resp), .csr_fault(csr_fault), .dm_req(dm_req),
  .dm_we(dm_we), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_ack(dm_ack),
  .debug_mode(debug_mode), .irq_mask(irq_mask), .count_inhibit(count_inhibit),
  .resv_drop(resv_drop), .illegal_instr(illegal_instr), .redirect_valid(redirect_valid),
  .redirect_pc(redirect_pc), .redirect_priv(redirect_priv), .hart_reset_req(hart_reset_req));
